// file: pric_pkg.sv
// constants, carrier types and helpers for the prioritized interrupt controller
// assumes a 125 MHz core clock and a 32-bit APB register port with byte addresses
package pric_pkg;
    localparam int NFLAG = 48;
    localparam int NSRC = 44;
    localparam int NTRAP = 4;
    localparam int NPRIO = 11;
    localparam int STK_DEPTH = 16;
    localparam int TIMED_DISABLE_W = 14;
    // register byte offsets
    localparam logic [7:0] OFS_FLAG0 = 8'h00;
    localparam logic [7:0] OFS_EN0 = 8'h0c;
    localparam logic [7:0] OFS_PRIO0 = 8'h18;
    localparam logic [7:0] OFS_GCR1 = 8'h44;
    localparam logic [7:0] OFS_GCR2 = 8'h48;
    localparam logic [7:0] OFS_CORE = 8'h4c;
    localparam logic [7:0] OFS_STAT = 8'h50;
    // field positions
    localparam int GCR1_NEST_BIT = 15;
    localparam int GCR2_ALT_BIT = 15;
    localparam int GCR2_TIMED_DISABLE_BIT = 14;
    localparam int CORE_IPL3_BIT = 3;
    localparam int STAT_IPL_LSB = 5;
    localparam int ADDR_ERR_TRAP = 2;
    localparam logic [15:0] PRIO_MASK = 16'h7777;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0] RST_LEVEL = 4'h0;
    // vector space
    localparam logic [23:0] IVT_BASE = 24'h000004;
    localparam logic [23:0] ALTERNATE_VECTOR_TABLE_BASE = 24'h000082;
    localparam logic [23:0] VEC_LAST = 24'h0000fe;
    localparam logic [5:0] TRAP_VEC0 = 6'h01;
    localparam logic [5:0] IRQ_VEC0 = 6'h08;
    localparam logic [3:0] TRAP_LVL0 = 4'hb;
    localparam logic [3:0] TIMED_DISABLE_CEIL = 4'h6;

    typedef struct packed {
        logic req;
        logic [3:0] level;
        logic [5:0] vecnum;
    } pric_irq_t;

    typedef struct packed {
        logic valid;
        logic [23:0] addr;
    } pric_fetch_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FETCH = 2'b10
    } pric_state_t;

    function automatic logic in_vec_space(input logic [23:0] a);
        return (a >= IVT_BASE) && (a <= VEC_LAST);
    endfunction

    function automatic logic [23:0] vec_word(input logic [23:0] base, input logic [5:0] v);
        return base + {17'h00000, v, 1'b0};
    endfunction
endpackage

// file: pric_arbiter.sv
// combinational pick of the winning peripheral source
// assumes flat 3-bit priorities per source and a 4-bit threshold from the caller
`timescale 1ns/1ps
`default_nettype none
module pric_arbiter import pric_pkg::*; #(
    parameter int N = NSRC
) (
    input wire logic [N-1:0] pend,
    input wire logic [3*N-1:0] prio,
    input wire logic [3:0] thresh,
    output logic hit,
    output logic [2:0] lvl,
    output logic [5:0] idx
);
    always_comb begin
        hit = 1'b0;
        lvl = 3'h0;
        idx = 6'h00;
        // walk downward so an equal level at a lower number takes over
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i] && prio[3*i +: 3] != 3'h0 &&
                {1'b0, prio[3*i +: 3]} > thresh && prio[3*i +: 3] >= lvl) begin
                hit = 1'b1;
                lvl = prio[3*i +: 3];
                idx = 6'(i);
            end
        end
    end
endmodule
`default_nettype wire

// file: pric_vec_guard.sv
// flags any normal fetch or jump that lands in vector space
// assumes fetch and jump requests from the core are one-cycle valid strobes
`timescale 1ns/1ps
`default_nettype none
module pric_vec_guard import pric_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire pric_fetch_t fetch,
    input wire pric_fetch_t jump,
    output logic addr_err_r
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_err_r <= 1'b0;
        end else begin
            addr_err_r <= (fetch.valid && in_vec_space(fetch.addr)) ||
                          (jump.valid && in_vec_space(jump.addr));
        end
    end
endmodule
`default_nettype wire

// file: pric_top.sv
// prioritized interrupt controller: flags, enables, priorities, nesting, vectoring
// assumes an APB master, a core that acknowledges requests and fetches from program memory
// Notes on behaviour
// - arbitrate up to 44 peripheral sources and 4 traps by priority.
// - vector word from program memory loads the 24-bit counter path.
// - both vector tables sit in low program memory from word 0x000004.
// - request flags set by sources, cleared only by software writes.
// - each source has its own enable bit in three enable registers.
// - priorities of all sources kept centrally in eleven priority registers.
// - CPU level is 4 bits, top bit in core control, rest in status.
// - first global register holds trap flags; second holds edge and table select.
// - a flag sets on its event regardless of the enable bit.
// - priority levels one to seven, seven highest.
// - priority zero never serviced, same as disabled.
// - nesting disable blocks new source interrupts, not traps, while one is in service.
// - CPU level ignores writes while nesting disable is one.
// - trigger options live in peripherals, not here.
// - timed disable blocks levels six and below, second global register bit 14 set meanwhile.
// - service loads the counter from that source's entry of 63 vectors.
// - vectors occupy words 0x000004 to 0x0000FE, 24-bit targets.
// - normal fetch from vector words raises an address error trap.
// - jump into vector space raises an address error trap.
// - equal priorities resolve to the lowest source number.
// - traps take fixed levels eleven to fourteen.
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pric_top import pric_pkg::*; #(
    parameter int DEPTH = STK_DEPTH
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [NFLAG-1:0] SRC_EVENT,
    input wire logic [NTRAP-1:0] TRAP_EVENT,
    output pric_irq_t IRQ,
    input wire logic IRQ_ACK,
    input wire logic IRQ_RETURN,
    output pric_fetch_t VEC_FETCH,
    input wire logic PMEM_VALID,
    input wire logic [23:0] PMEM_DATA,
    output pric_fetch_t PC_LOAD,
    input wire pric_fetch_t FETCH,
    input wire pric_fetch_t JUMP,
    input wire logic TIMED_DISABLE_START,
    input wire logic [TIMED_DISABLE_W-1:0] TIMED_DISABLE_COUNT,
    input wire logic INSN_DONE,
    output logic [3:0] CPU_LEVEL,
    output logic [2:0] EXT_EDGE_SEL,
    output logic ADDR_ERROR
);
    logic [NFLAG-1:0] flag_r;
    logic [NFLAG-1:0] flag_nxt;
    logic [NFLAG-1:0] en_r;
    logic [15:0] prio_r [NPRIO];
    logic [NTRAP-1:0] trap_r;
    logic nest_dis_r;
    logic alt_r;
    logic [2:0] edge_r;
    logic [3:0] ipl_r;
    logic [TIMED_DISABLE_W-1:0] timed_disable_r;
    logic [3:0] stk_r [DEPTH];
    logic [4:0] depth_r;
    pric_state_t state_r;
    pric_irq_t irq_r;
    pric_fetch_t vfetch_r;
    pric_fetch_t pcload_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic addr_err;
    logic wr_en;
    logic rd_phase;
    logic [31:0] rdata;
    logic rhit;
    logic [3*NSRC-1:0] prio_flat;
    logic [3:0] thresh;
    logic hit;
    logic [2:0] hit_lvl;
    logic [5:0] hit_idx;
    logic trap_hit;
    logic [1:0] trap_idx;
    logic [3:0] trap_lvl;
    logic [3:0] idx_w;

    // enable register number 0..2 from its byte address, kept to two bits
    function automatic logic [1:0] en_slot(input logic [7:0] a);
        return 2'(a[3:2] - 2'd3);
    endfunction

    assign rd_phase = PSEL && PENABLE && !pready_r;
    assign wr_en = PSEL && PENABLE && pready_r && PWRITE;

    // apb: one wait state, data and error registered with pready
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= rd_phase;
            prdata_r <= (rd_phase && !PWRITE && rhit) ? rdata : 32'h00000000;
            pslverr_r <= rd_phase && !rhit;
        end
    end

    // read mux and address decode
    always_comb begin
        rdata = 32'h00000000;
        rhit = 1'b1;
        idx_w = 4'((PADDR - OFS_PRIO0) >> 2);
        if (PADDR >= OFS_FLAG0 && PADDR < OFS_EN0 && PADDR[1:0] == 2'b00) begin
            rdata[15:0] = flag_r[16*PADDR[3:2] +: 16];
        end else if (PADDR >= OFS_EN0 && PADDR < OFS_PRIO0 && PADDR[1:0] == 2'b00) begin
            rdata[15:0] = en_r[16*en_slot(PADDR) +: 16];
        end else if (PADDR >= OFS_PRIO0 && PADDR < OFS_GCR1 && PADDR[1:0] == 2'b00) begin
            rdata[15:0] = prio_r[idx_w];
        end else if (PADDR == OFS_GCR1) begin
            rdata[GCR1_NEST_BIT] = nest_dis_r;
            rdata[NTRAP-1:0] = trap_r;
        end else if (PADDR == OFS_GCR2) begin
            rdata[GCR2_ALT_BIT] = alt_r;
            rdata[GCR2_TIMED_DISABLE_BIT] = timed_disable_r != '0;
            rdata[2:0] = edge_r;
        end else if (PADDR == OFS_CORE) begin
            rdata[CORE_IPL3_BIT] = ipl_r[3];
        end else if (PADDR == OFS_STAT) begin
            rdata[STAT_IPL_LSB +: 3] = ipl_r[2:0];
        end else begin
            rhit = 1'b0;
        end
    end

    // request flags: events set, software writes of zero clear, set wins
    always_comb begin
        flag_nxt = flag_r;
        if (wr_en && PADDR >= OFS_FLAG0 && PADDR < OFS_EN0 && PADDR[1:0] == 2'b00) begin
            flag_nxt[16*PADDR[3:2] +: 16] = flag_r[16*PADDR[3:2] +: 16] & PWDATA[15:0];
        end
        flag_nxt = flag_nxt | SRC_EVENT;
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            flag_r <= '0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // enables and priorities
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            en_r <= '0;
            for (int i = 0; i < NPRIO; i++) begin
                prio_r[i] <= RST_WORD;
            end
        end else if (wr_en && PADDR[1:0] == 2'b00) begin
            if (PADDR >= OFS_EN0 && PADDR < OFS_PRIO0) begin
                en_r[16*en_slot(PADDR) +: 16] <= PWDATA[15:0];
            end else if (PADDR >= OFS_PRIO0 && PADDR < OFS_GCR1) begin
                prio_r[idx_w] <= PWDATA[15:0] & PRIO_MASK;
            end
        end
    end

    // global controls and trap flags
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            nest_dis_r <= 1'b0;
            trap_r <= '0;
            alt_r <= 1'b0;
            edge_r <= 3'h0;
        end else begin
            if (wr_en && PADDR == OFS_GCR1) begin
                nest_dis_r <= PWDATA[GCR1_NEST_BIT];
                trap_r <= (trap_r & PWDATA[NTRAP-1:0]) | TRAP_EVENT;
            end else begin
                trap_r <= trap_r | TRAP_EVENT;
            end
            if (addr_err) begin
                trap_r[ADDR_ERR_TRAP] <= 1'b1;
            end
            if (wr_en && PADDR == OFS_GCR2) begin
                alt_r <= PWDATA[GCR2_ALT_BIT];
                edge_r <= PWDATA[2:0];
            end
        end
    end

    // timed disable counter, retired instructions count it down
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            timed_disable_r <= '0;
        end else if (TIMED_DISABLE_START) begin
            timed_disable_r <= TIMED_DISABLE_COUNT;
        end else if (INSN_DONE && timed_disable_r != '0) begin
            timed_disable_r <= timed_disable_r - 1'b1;
        end
    end

    // arbitration inputs
    always_comb begin
        prio_flat = '0;
        for (int i = 0; i < NSRC; i++) begin
            prio_flat[3*i +: 3] = prio_r[i/4][4*(i%4) +: 3];
        end
        thresh = ipl_r;
        if (timed_disable_r != '0 && ipl_r < TIMED_DISABLE_CEIL) begin
            thresh = TIMED_DISABLE_CEIL;
        end
        trap_hit = 1'b0;
        trap_idx = 2'd0;
        for (int i = 0; i < NTRAP; i++) begin
            if (trap_r[i]) begin
                trap_hit = 1'b1;
                trap_idx = 2'(i);
            end
        end
        trap_lvl = TRAP_LVL0 + {2'b00, trap_idx};
    end

    pric_arbiter #(
        .N(NSRC)
    ) pric_arbiter_i (
        .pend(flag_r[NSRC-1:0] & en_r[NSRC-1:0]),
        .prio(prio_flat),
        .thresh(thresh),
        .hit(hit),
        .lvl(hit_lvl),
        .idx(hit_idx)
    );

    pric_vec_guard pric_vec_guard_i (
        .clk(CLOCK),
        .rst_n(RSTN),
        .fetch(FETCH),
        .jump(JUMP),
        .addr_err_r(addr_err)
    );

    // request to the core, traps outrank every maskable level
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            irq_r <= '0;
        end else if (state_r != ST_IDLE || (IRQ_ACK && irq_r.req)) begin
            irq_r <= '0;
        end else if (trap_hit && trap_lvl > ipl_r) begin
            irq_r.req <= 1'b1;
            irq_r.level <= trap_lvl;
            irq_r.vecnum <= TRAP_VEC0 + {4'h0, trap_idx};
        end else if (hit && !(nest_dis_r && depth_r != 5'd0)) begin
            irq_r.req <= 1'b1;
            irq_r.level <= {1'b0, hit_lvl};
            irq_r.vecnum <= IRQ_VEC0 + hit_idx;
        end else begin
            irq_r <= '0;
        end
    end

    // service sequence: acknowledge, read vector word, load counter
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= ST_IDLE;
            vfetch_r <= '0;
            pcload_r <= '0;
        end else begin
            pcload_r.valid <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (IRQ_ACK && irq_r.req) begin
                        vfetch_r.valid <= 1'b1;
                        vfetch_r.addr <= vec_word(alt_r ? ALTERNATE_VECTOR_TABLE_BASE : IVT_BASE,
                                                  irq_r.vecnum);
                        state_r <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (PMEM_VALID) begin
                        vfetch_r.valid <= 1'b0;
                        pcload_r.valid <= 1'b1;
                        pcload_r.addr <= PMEM_DATA;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // cpu level with nesting stack; hardware updates outrank software writes
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ipl_r <= RST_LEVEL;
            depth_r <= 5'd0;
            for (int i = 0; i < DEPTH; i++) begin
                stk_r[i] <= RST_LEVEL;
            end
        end else if (state_r == ST_IDLE && IRQ_ACK && irq_r.req) begin
            if (depth_r < 5'(DEPTH)) begin
                stk_r[depth_r[3:0]] <= ipl_r;
                depth_r <= depth_r + 5'd1;
            end
            ipl_r <= irq_r.level;
        end else if (IRQ_RETURN && depth_r != 5'd0) begin
            ipl_r <= stk_r[4'(depth_r - 5'd1)];
            depth_r <= depth_r - 5'd1;
        end else if (wr_en && !nest_dis_r) begin
            if (PADDR == OFS_CORE) begin
                ipl_r[3] <= PWDATA[CORE_IPL3_BIT];
            end else if (PADDR == OFS_STAT) begin
                ipl_r[2:0] <= PWDATA[STAT_IPL_LSB +: 3];
            end
        end
    end

    // outputs straight from flops
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            CPU_LEVEL <= RST_LEVEL;
            EXT_EDGE_SEL <= 3'h0;
            ADDR_ERROR <= 1'b0;
        end else begin
            CPU_LEVEL <= ipl_r;
            EXT_EDGE_SEL <= edge_r;
            ADDR_ERROR <= addr_err;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign IRQ = irq_r;
    assign VEC_FETCH = vfetch_r;
    assign PC_LOAD = pcload_r;
endmodule
`default_nettype wire

// file: pric_chk.sv
// checker on the interrupt controller top ports
// assumes it is bound onto pric_top
`timescale 1ns/1ps
`default_nettype none
module pric_chk import pric_pkg::*; (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire pric_irq_t IRQ,
    input wire logic IRQ_ACK,
    input wire pric_fetch_t VEC_FETCH,
    input wire logic PMEM_VALID,
    input wire logic [23:0] PMEM_DATA,
    input wire pric_fetch_t PC_LOAD,
    input wire pric_fetch_t FETCH,
    input wire pric_fetch_t JUMP,
    input wire logic [3:0] CPU_LEVEL,
    input wire logic ADDR_ERROR
);
    logic bad;
    logic take;
    logic [3:0] lv;
    assign bad = (FETCH.valid && FETCH.addr >= 24'h4 && FETCH.addr <= 24'hfe)
        || (JUMP.valid && JUMP.addr >= 24'h4 && JUMP.addr <= 24'hfe);
    assign take = IRQ_ACK && IRQ.req;
    assign lv = IRQ.level;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    sequence s_take;
        take && !VEC_FETCH.valid;
    endsequence
    sequence s_ret;
        VEC_FETCH.valid && PMEM_VALID;
    endsequence
    AST_GUARD: assert property (bad |-> ##2 ADDR_ERROR)
        else $error("no address error after vector space fetch");
    AST_GUARD_CAUSE: assert property (ADDR_ERROR |-> $past(bad, 2))
        else $error("address error without cause");
    AST_PRIO_ZERO: assert property (IRQ.req |-> IRQ.level != 4'h0)
        else $error("request at level zero");
    AST_LVL_RANGE: assert property (IRQ.req && IRQ.vecnum >= IRQ_VEC0
        |-> IRQ.level inside {[4'h1:4'h7]}) else $error("source level out of range");
    AST_TRAP_LVL: assert property (IRQ.req && IRQ.vecnum < IRQ_VEC0 |-> IRQ.level[3])
        else $error("trap below level eight");
    AST_VEC_CAUSE: assert property ($rose(VEC_FETCH.valid) |-> $past(take))
        else $error("vector fetch without acknowledge");
    AST_VEC_RANGE: assert property (VEC_FETCH.valid |-> VEC_FETCH.addr >= IVT_BASE
        && VEC_FETCH.addr <= VEC_LAST && !VEC_FETCH.addr[0]) else $error("vector address bad");
    AST_PC_LOAD: assert property (s_ret |=> PC_LOAD.valid
        && PC_LOAD.addr == $past(PMEM_DATA)) else $error("counter load mismatch");
    AST_LVL_TAKE: assert property (s_take |-> ##2 CPU_LEVEL == $past(lv, 2))
        else $error("cpu level not raised");
endmodule
bind pric_top pric_chk pric_chk_i (.CLOCK(CLOCK), .RSTN(RSTN), .IRQ(IRQ),
    .IRQ_ACK(IRQ_ACK), .VEC_FETCH(VEC_FETCH), .PMEM_VALID(PMEM_VALID),
    .PMEM_DATA(PMEM_DATA), .PC_LOAD(PC_LOAD), .FETCH(FETCH), .JUMP(JUMP),
    .CPU_LEVEL(CPU_LEVEL), .ADDR_ERROR(ADDR_ERROR));
`default_nettype wire

// file: pric_core_model.sv
// core and program memory model facing the controller
// assumes registered IRQ and VEC_FETCH levels from the controller
`timescale 1ns/1ps
`default_nettype none
module pric_core_model import pric_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ack_en,
    input wire logic [2:0] dly,
    input wire pric_irq_t irq,
    input wire pric_fetch_t vec_fetch,
    output logic irq_ack,
    output logic pmem_valid,
    output logic [23:0] pmem_data
);
    logic [2:0] cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= ack_en && irq.req && !irq_ack;
        end
    end
    // released data bus shows the inverse of its last value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'h0;
            pmem_valid <= 1'b0;
            pmem_data <= 24'h0;
        end else if (vec_fetch.valid && !pmem_valid && cnt == dly) begin
            pmem_valid <= 1'b1;
            pmem_data <= vec_fetch.addr ^ 24'ha5a5a5;
        end else begin
            pmem_valid <= 1'b0;
            pmem_data <= ~pmem_data;
            cnt <= (vec_fetch.valid && !pmem_valid) ? cnt + 3'h1 : 3'h0;
        end
    end
endmodule
`default_nettype wire

// file: prioritized_interrupt_controller_test.sv
// self-checking bench for the interrupt controller
// assumes pric_top, pric_core_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_controller_test import pric_pkg::*;;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, iret = 0;
    logic ds = 0, idn = 0, ack_en = 0, rerr, alt = 0;
    logic [7:0] pa = 0;
    logic [31:0] pwd = 0, prd, rdat, sd = 32'h60c19819, r;
    logic [NFLAG-1:0] sev = 0;
    logic [3:0] tev = 0, lvl;
    logic [TIMED_DISABLE_W-1:0] dc = 0;
    logic [2:0] dly = 0, ees;
    pric_fetch_t fet = 0, jmp = 0, vf, pcl;
    pric_irq_t irq;
    logic prdy, perr, ack, pmv, aerr;
    logic [23:0] pmd, fa, la;
    int n_fail = 0, n_compared = 0, cyc = 0, n;
    always #4 clk = ~clk;
    pric_top pric_top_i (.CLOCK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
        .PSLVERR(perr), .SRC_EVENT(sev), .TRAP_EVENT(tev), .IRQ(irq), .IRQ_ACK(ack),
        .IRQ_RETURN(iret), .VEC_FETCH(vf), .PMEM_VALID(pmv), .PMEM_DATA(pmd),
        .PC_LOAD(pcl), .FETCH(fet), .JUMP(jmp), .TIMED_DISABLE_START(ds), .TIMED_DISABLE_COUNT(dc),
        .INSN_DONE(idn), .CPU_LEVEL(lvl), .EXT_EDGE_SEL(ees), .ADDR_ERROR(aerr));
    pric_core_model pric_core_model_i (.clk(clk), .rst_n(rstn), .ack_en(ack_en),
        .dly(dly), .irq(irq), .vec_fetch(vf), .irq_ack(ack), .pmem_valid(pmv),
        .pmem_data(pmd));
    function logic [31:0] rnd();
        sd ^= sd << 13;
        sd ^= sd >> 17;
        sd ^= sd << 5;
        return sd;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        rdat = prd;
        rerr = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        apb(0, a, 0);
        chk("prdata", {16'h0, e}, rdat);
    endtask
    task automatic ev(input int s);
        @(posedge clk);
        sev[s] <= 1;
        @(posedge clk);
        sev[s] <= 0;
    endtask
    task automatic wreq(input int c);
        @(negedge clk);
        for (n = 0; n < c && !irq.req; n++) @(negedge clk);
    endtask
    task automatic take_irq;
        @(posedge clk);
        ack_en <= 1;
        while (!vf.valid) @(negedge clk);
        fa = vf.addr;
        while (!pcl.valid) @(negedge clk);
        la = pcl.addr;
        @(posedge clk);
        ack_en <= 0;
    endtask
    task automatic serve(input int s, input logic [2:0] p);
        logic [7:0] fr, pr;
        logic [23:0] va;
        fr = OFS_FLAG0 + 8'(4 * (s / 16));
        pr = OFS_PRIO0 + 8'(4 * (s / 4));
        va = (alt ? ALTERNATE_VECTOR_TABLE_BASE : IVT_BASE) + 24'(2 * (8 + s));
        ev(s);
        rd(fr, 16'(1 << (s % 16)));
        apb(1, fr, 0);
        rd(fr, 0);
        apb(1, pr, 32'(p) << (4 * (s % 4)));
        ev(s);
        apb(1, fr + OFS_EN0, 32'(1) << (s % 16));
        wreq(30);
        chk("irq level", 32'(p), irq.level);
        chk("irq vector", 32'(8 + s), irq.vecnum);
        take_irq;
        chk("vector address", va, fa);
        chk("counter load", va ^ 24'ha5a5a5, la);
        repeat (3) @(negedge clk);
        chk("cpu level", 32'(p), lvl);
        apb(1, fr + OFS_EN0, 0);
        apb(1, fr, 0);
        @(posedge clk);
        iret <= 1;
        @(posedge clk);
        iret <= 0;
    endtask
    task automatic grd(input logic j, input logic [23:0] a, input logic e);
        logic seen;
        seen = 0;
        @(posedge clk);
        if (j) jmp <= {1'b1, a};
        else fet <= {1'b1, a};
        @(posedge clk);
        jmp.valid <= 0;
        fet.valid <= 0;
        repeat (5) begin
            @(negedge clk);
            seen |= aerr;
        end
        chk("address error", 32'(e), 32'(seen));
        rd(OFS_GCR1, 16'(e) << ADDR_ERR_TRAP);
        apb(1, OFS_GCR1, 0);
    endtask
    task automatic test_done;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            test_done;
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1;
        rd(OFS_GCR1, 0);
        rd(OFS_STAT, 0);
        apb(0, 8'hfc, 0);
        chk("slverr", 1, rerr);
        rd(OFS_PRIO0, 0);
        apb(1, OFS_PRIO0, 32'hffff);
        rd(OFS_PRIO0, PRIO_MASK);
        $display("registers done");
        serve(0, 7);
        serve(43, 1);
        apb(1, OFS_GCR2, 32'h8005);
        rd(OFS_GCR2, 16'h8005);
        chk("edge select", 5, ees);
        alt = 1;
        serve(17, 5);
        alt = 0;
        apb(1, OFS_GCR2, 0);
        repeat (6) begin
            r = rnd();
            dly <= r[14:12];
            serve(r % 44, 3'(r[10:8] % 7 + 1));
        end
        $display("service done");
        apb(1, OFS_PRIO0, 0);
        apb(1, OFS_EN0, 32'h6);
        ev(2);
        ev(1);
        wreq(8);
        chk("req", 0, irq.req);
        apb(1, OFS_PRIO0, 32'h330);
        wreq(20);
        chk("irq vector", 9, irq.vecnum);
        apb(1, OFS_EN0, 0);
        apb(1, OFS_FLAG0, 0);
        apb(1, OFS_GCR1, 32'h8000);
        apb(1, OFS_STAT, 32'he0);
        rd(OFS_STAT, 0);
        apb(1, OFS_GCR1, 0);
        apb(1, OFS_STAT, 32'he0);
        rd(OFS_STAT, 16'he0);
        apb(1, OFS_PRIO0 + 8'h4, 32'h70);
        apb(1, OFS_EN0, 32'h20);
        ev(5);
        wreq(8);
        chk("req", 0, irq.req);
        apb(1, OFS_STAT, 32'hc0);
        wreq(20);
        chk("req", 1, irq.req);
        @(posedge clk);
        ds <= 1;
        dc <= 2;
        @(posedge clk);
        ds <= 0;
        apb(1, OFS_PRIO0 + 8'h4, 32'h60);
        apb(1, OFS_STAT, 0);
        rd(OFS_GCR2, 16'h4000);
        chk("req", 0, irq.req);
        repeat (2) begin
            @(posedge clk);
            idn <= 1;
            @(posedge clk);
            idn <= 0;
        end
        rd(OFS_GCR2, 0);
        wreq(20);
        chk("req", 1, irq.req);
        apb(1, OFS_EN0, 0);
        apb(1, OFS_FLAG0, 0);
        apb(1, OFS_GCR1, 32'h8000);
        apb(1, OFS_PRIO0 + 8'h4, 32'h71);
        apb(1, OFS_EN0, 32'h30);
        ev(4);
        wreq(20);
        take_irq;
        ev(5);
        wreq(8);
        chk("req", 0, irq.req);
        apb(1, OFS_GCR1, 0);
        wreq(20);
        chk("req", 1, irq.req);
        apb(1, OFS_EN0, 0);
        apb(1, OFS_FLAG0, 0);
        @(posedge clk);
        iret <= 1;
        @(posedge clk);
        iret <= 0;
        $display("masking done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            tev[i] <= 1;
            @(posedge clk);
            tev[i] <= 0;
            wreq(20);
            chk("trap level", 32'(TRAP_LVL0 + i), irq.level);
            chk("trap vector", 32'(TRAP_VEC0 + i), irq.vecnum);
            rd(OFS_GCR1, 16'(1 << i));
            apb(1, OFS_GCR1, 0);
        end
        r = rnd();
        grd(0, 24'(4 + r % 251), 1);
        grd(1, 24'hfe, 1);
        grd(0, 24'hff, 0);
        grd(1, 24'h3, 0);
        $display("traps done");
        test_done;
    end
endmodule
`default_nettype wire
